// ==== src/sdb_regs.svh ====
// Offsets, field positions, codes and reset values of the synchronous DRAM
// core. Assumes inclusion by bare name from the package and the core.
`ifndef SDB_REGS_SVH
`define SDB_REGS_SVH

// ----------------------------------------------------------------------------
// Operating configuration word fields
// ----------------------------------------------------------------------------
`define SDB_CFG_W 12
`define SDB_CFG_RST 12'h000
`define SDB_BURST_LEN_LSB 0
`define SDB_BURST_LEN_MSB 2
`define SDB_BURST_ORDER_BIT 3
`define SDB_READ_LAT_LSB 4
`define SDB_READ_LAT_MSB 6
`define SDB_OP_MODE_LO_BIT 7
`define SDB_OP_MODE_HI_BIT 8
`define SDB_WRITE_SINGLE_BIT 9

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define SDB_BL_1 3'h0
`define SDB_BL_2 3'h1
`define SDB_BL_4 3'h2
`define SDB_BL_8 3'h3
`define SDB_BL_PAGE 3'h7
`define SDB_LAT_2 3'h2
`define SDB_LAT_3 3'h3

// ----------------------------------------------------------------------------
// Address line roles and buffering
// ----------------------------------------------------------------------------
`define SDB_ALL_BANKS_BIT 10
`define SDB_WR_FIFO_DEPTH 8

`endif

// ==== src/sdb_pkg.sv ====
// Types shared by the synchronous DRAM core.
// Assumes the field header is on the include path.
package sdb_pkg;
  `include "sdb_regs.svh"

  typedef enum logic [3:0] {
    CMD_INHIBIT,
    CMD_NOP,
    CMD_ACTIVE,
    CMD_READ,
    CMD_WRITE,
    CMD_BURST_STOP,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_LOAD_CFG
  } sdb_cmd_t;

  typedef logic [`SDB_CFG_W-1:0] sdb_cfg_t;
endpackage

// ==== src/sdb_fifo.sv ====
// Write-data FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sdb_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,            // Clock.
  input wire logic rst_n_i,              // Synchronous reset, active low.
  input wire logic in_valid_i,           // Word offered.
  output logic in_ready_o,               // Room for a word.
  input wire logic [WIDTH-1:0] in_data_i, // Word in.
  output logic out_valid_o,              // Word available.
  input wire logic out_ready_i,          // Drain takes the word.
  output logic [WIDTH-1:0] out_data_o    // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sdb_fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // sdb_fifo

// ==== src/sdb_core.sv ====
// Synchronous DRAM core: command decode, bank rows, configuration word,
// burst sequencing, read latency and the storage array.
// Assumes the controller drives all inputs from the same clock.
//
// Notes on behaviour
// - All inputs sampled on rising clock edge; read data launched from it.
// - Four banks of 4,096 rows by 256 columns of 16 bits.
// - ACTIVE latches bank select and twelve row lines to open a row.
// - READ/WRITE needs an open row; eight low lines give start column.
// - Configuration word holds until the next load.
// - Bits 0-2 length, 3 order, 4-6 latency, 7-8 mode, 9 write mode.
// - Lengths 1, 2, 4, 8 both orders; full page sequential only.
// - Full-page burst wraps in page until ended by burst stop, precharge or a new read/write.
// - Burst stays inside aligned block of its length.
// - Sequential order increments start modulo length within block.
// - Interleaved order accesses start XOR k.
// - Latency two or three; first word valid by edge n+m.
// - Data outputs start driving from edge n+m-1.
// - Normal operation needs both mode bits zero; the core ignores bits 7-8.
// - Write-single bit makes every write one location.
`timescale 1ns/1ns
`include "sdb_regs.svh"
module sdb_core
  import sdb_pkg::*;
#(
  parameter int BANK_W = 2,
  parameter int ROW_W = 12,
  parameter int COL_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk_i,                 // Device clock, 25 MHz.
  input wire logic rst_n_i,                   // Synchronous reset, active low.
  input wire logic cke_i,                     // Clock enable, high active.
  input wire logic cs_n_i,                    // Chip select, active low.
  input wire logic ras_n_i,                   // Row strobe, active low.
  input wire logic cas_n_i,                   // Column strobe, active low.
  input wire logic we_n_i,                    // Write enable, active low.
  input wire logic bank_sel_lo_i,             // Bank select, low bit.
  input wire logic bank_sel_hi_i,             // Bank select, high bit.
  input wire logic [ROW_W-1:0] row_addr_lines_i, // Address lines.
  input wire logic [DATA_W/8-1:0] dqm_i,      // Write byte masks, high masks.
  input wire logic [DATA_W-1:0] dq_i,         // Data pins, input side.
  output logic [DATA_W-1:0] dq_o,             // Data pins, output side.
  output logic dq_oe_o,                       // Drive enable of data pins.
  output logic wr_ready_o,                    // Write buffer has room.
  output logic cfg_loaded_o                   // Configuration word written.
);
  localparam int ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int BYTES = DATA_W / 8;
  localparam int NBANK = 1 << BANK_W;
  localparam int ENTRY_W = ADDR_W + BYTES + DATA_W;

  if (BANK_W != 2 || ROW_W < `SDB_CFG_W || COL_W < 3 || COL_W > ROW_W ||
      DATA_W % 8 != 0) begin : g_bad_shape
    $error("sdb_core shape not supported");
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic sdb_cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    sdb_cmd_t c;
    c = CMD_INHIBIT;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACTIVE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h6: c = CMD_BURST_STOP;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = CMD_REFRESH;
        default: c = CMD_LOAD_CFG;
      endcase
    end
    return c;
  endfunction

  // Offset mask of the aligned block; all ones for a full page.
  function automatic logic [COL_W-1:0] block_mask(input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = '0;
    case (code)
      `SDB_BL_2: m = COL_W'(1);
      `SDB_BL_4: m = COL_W'(3);
      `SDB_BL_8: m = COL_W'(7);
      `SDB_BL_PAGE: m = '1;
      default: m = '0;
    endcase
    return m;
  endfunction

  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] k,
                                                 input logic [COL_W-1:0] mask,
                                                 input logic interleave);
    logic [COL_W-1:0] off;
    off = interleave ? (start ^ k) : COL_W'(start + k);
    return (start & ~mask) | (off & mask);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sdb_cmd_t cmd;
  logic [BANK_W-1:0] cmd_bank;
  logic [COL_W-1:0] col_addr_lines;
  sdb_cfg_t cfg;
  sdb_cfg_t next_cfg;
  logic next_cfg_loaded;
  logic [NBANK-1:0] row_open;
  logic [NBANK-1:0] next_row_open;
  logic [ROW_W-1:0] open_row [NBANK];
  logic [ROW_W-1:0] next_open_row [NBANK];
  logic busy;
  logic next_busy;
  logic bwrite;
  logic next_bwrite;
  logic [BANK_W-1:0] bbank;
  logic [BANK_W-1:0] next_bbank;
  logic [COL_W-1:0] bstart;
  logic [COL_W-1:0] next_bstart;
  logic [COL_W-1:0] bk;
  logic [COL_W-1:0] next_bk;
  logic [COL_W-1:0] bmask;
  logic [COL_W-1:0] next_bmask;
  logic binter;
  logic next_binter;
  logic bpage;
  logic next_bpage;
  logic p_valid;
  logic next_p_valid;
  logic [ADDR_W-1:0] p_addr;
  logic [ADDR_W-1:0] next_p_addr;
  logic [DATA_W-1:0] next_dq;
  logic next_dq_oe;
  logic rd_fire;
  logic [ADDR_W-1:0] rd_addr;
  logic sel_valid;
  logic [ADDR_W-1:0] sel_addr;
  logic cfg_lat3;
  logic [COL_W-1:0] new_mask;
  logic new_page;
  logic new_inter;
  logic fifo_in_valid;
  logic [ENTRY_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ENTRY_W-1:0] fifo_out_data;
  logic [DATA_W-1:0] array_mem [NBANK << (ROW_W + COL_W)];

  // Clock enable low is treated as a NOP on that edge.
  assign cmd = cke_i ? decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i)
                     : CMD_NOP;
  assign cmd_bank = {bank_sel_hi_i, bank_sel_lo_i};
  assign col_addr_lines = row_addr_lines_i[COL_W-1:0];
  assign cfg_lat3 = (cfg[`SDB_READ_LAT_MSB:`SDB_READ_LAT_LSB] == `SDB_LAT_3);

  // --------------------------------------------------------------------------
  // Command and burst engine
  // --------------------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_cfg_loaded = cfg_loaded_o;
    next_row_open = row_open;
    next_open_row = open_row;
    next_busy = busy;
    next_bwrite = bwrite;
    next_bbank = bbank;
    next_bstart = bstart;
    next_bk = bk;
    next_bmask = bmask;
    next_binter = binter;
    next_bpage = bpage;
    // Full page is sequential only; interleave is ignored for it.
    new_mask = block_mask(cfg[`SDB_BURST_LEN_MSB:`SDB_BURST_LEN_LSB]);
    new_page = (cfg[`SDB_BURST_LEN_MSB:`SDB_BURST_LEN_LSB] == `SDB_BL_PAGE);
    new_inter = cfg[`SDB_BURST_ORDER_BIT] && !new_page;
    rd_fire = busy && !bwrite;
    rd_addr = {bbank, open_row[bbank], burst_col(bstart, bk, bmask, binter)};
    fifo_in_valid = 1'b0;
    fifo_in_data = {{ADDR_W{1'b0}}, ~dqm_i, dq_i};
    if (busy) begin
      if (bwrite) begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {bbank, open_row[bbank],
                        burst_col(bstart, bk, bmask, binter), ~dqm_i, dq_i};
      end
      if (!bpage && bk == bmask) begin
        next_busy = 1'b0;
      end else begin
        next_bk = bk + 1'b1;
      end
    end
    case (cmd)
      CMD_ACTIVE: begin
        next_row_open[cmd_bank] = 1'b1;
        next_open_row[cmd_bank] = row_addr_lines_i;
      end
      CMD_PRECHARGE: begin
        if (row_addr_lines_i[`SDB_ALL_BANKS_BIT]) begin
          next_row_open = '0;
          next_busy = 1'b0;
        end else begin
          next_row_open[cmd_bank] = 1'b0;
          if (cmd_bank == bbank) begin
            next_busy = 1'b0;
          end
        end
      end
      CMD_BURST_STOP: next_busy = 1'b0;
      CMD_LOAD_CFG: begin
        next_cfg = row_addr_lines_i[`SDB_CFG_W-1:0];
        next_cfg_loaded = 1'b1;
      end
      CMD_READ, CMD_WRITE: begin
        if (row_open[cmd_bank]) begin
          next_bbank = cmd_bank;
          next_bstart = col_addr_lines;
          next_bmask = new_mask;
          next_binter = new_inter;
          next_bpage = new_page;
          next_bwrite = (cmd == CMD_WRITE);
          next_busy = 1'b1;
          next_bk = '0;
          if (cmd == CMD_WRITE) begin
            // The first write word arrives with the command itself.
            fifo_in_valid = 1'b1;
            fifo_in_data = {cmd_bank, open_row[cmd_bank], col_addr_lines,
                            ~dqm_i, dq_i};
            next_bk = COL_W'(1);
            if (cfg[`SDB_WRITE_SINGLE_BIT] || (!new_page &&
                new_mask == '0)) begin
              next_busy = 1'b0;
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Read latency pipeline
  // --------------------------------------------------------------------------
  always_comb begin
    next_p_valid = rd_fire;
    next_p_addr = rd_addr;
    sel_valid = cfg_lat3 ? p_valid : rd_fire;
    sel_addr = cfg_lat3 ? p_addr : rd_addr;
    next_dq_oe = sel_valid;
    next_dq = sel_valid ? array_mem[sel_addr] : dq_o;
    // The array has one port; reads take it and writes wait in the FIFO.
    fifo_out_ready = !sel_valid;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg <= `SDB_CFG_RST;
      cfg_loaded_o <= 1'b0;
      row_open <= '0;
      busy <= 1'b0;
      bwrite <= 1'b0;
      bbank <= '0;
      bstart <= '0;
      bk <= '0;
      bmask <= '0;
      binter <= 1'b0;
      bpage <= 1'b0;
      p_valid <= 1'b0;
      p_addr <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      cfg <= next_cfg;
      cfg_loaded_o <= next_cfg_loaded;
      row_open <= next_row_open;
      busy <= next_busy;
      bwrite <= next_bwrite;
      bbank <= next_bbank;
      bstart <= next_bstart;
      bk <= next_bk;
      bmask <= next_bmask;
      binter <= next_binter;
      bpage <= next_bpage;
      p_valid <= next_p_valid;
      p_addr <= next_p_addr;
      dq_o <= next_dq;
      dq_oe_o <= next_dq_oe;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    open_row <= next_open_row;
  end

  // --------------------------------------------------------------------------
  // Write buffer and array
  // --------------------------------------------------------------------------
  sdb_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(`SDB_WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(wr_ready_o),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge sys_clk_i) begin
    if (fifo_out_valid && fifo_out_ready) begin
      for (int b = 0; b < BYTES; b++) begin
        if (fifo_out_data[DATA_W + b]) begin
          array_mem[fifo_out_data[ENTRY_W-1 -: ADDR_W]][b*8 +: 8] <=
            fifo_out_data[b*8 +: 8];
        end
      end
    end
  end
endmodule // sdb_core

// ==== verification/sdb_core_monitor.sv ====
// Checker of data-pin timing and configuration state of the DRAM core.
// Assumes it is bound to sdb_core and sees only that module's ports.
`timescale 1ns/1ns
module sdb_core_monitor #(
  parameter int ROW_W = 12
) (
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic cke_i, // Clock enable.
  input wire logic cs_n_i, // Chip select.
  input wire logic ras_n_i, // Row strobe.
  input wire logic cas_n_i, // Column strobe.
  input wire logic we_n_i, // Write enable.
  input wire logic bank_sel_lo_i, // Bank low bit.
  input wire logic bank_sel_hi_i, // Bank high bit.
  input wire logic [ROW_W-1:0] row_addr_lines_i, // Address lines.
  input wire logic dq_oe_o, // Data drive enable.
  input wire logic cfg_loaded_o // Configuration written.
);
  // --------------------------------------------------------------------
  // Command tracking
  // --------------------------------------------------------------------
  logic tk;
  logic [2:0] op;
  logic [1:0] bk;
  logic [3:0] open_b;
  logic [11:0] cfg;
  logic [2:0] cut;
  logic [8:0] run;
  logic [8:0] blen;
  logic rd_ok;
  logic rd_d1;
  logic rd_d2;
  logic endc;
  logic quiet;
  logic lat3;
  assign tk = cke_i && !cs_n_i;
  assign op = {ras_n_i, cas_n_i, we_n_i};
  assign bk = {bank_sel_hi_i, bank_sel_lo_i};
  assign rd_ok = tk && op == 3'h5 && open_b[bk];
  assign endc = tk && op inside {3'h2, 3'h4, 3'h5, 3'h6};
  assign quiet = !dq_oe_o && !rd_d1 && !rd_d2;
  assign lat3 = cfg[6:4] == 3'h3;
  always_comb begin
    case (cfg[2:0])
      3'h1: blen = 9'h002;
      3'h2: blen = 9'h004;
      3'h3: blen = 9'h008;
      3'h7: blen = 9'h100;
      default: blen = 9'h001;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      open_b <= 4'h0;
      cfg <= 12'h000;
      cut <= 3'h0;
      run <= 9'h000;
      rd_d1 <= 1'b0;
      rd_d2 <= 1'b0;
    end else begin
      if (tk && op == 3'h3) begin
        open_b[bk] <= 1'b1;
      end
      if (tk && op == 3'h2) begin
        open_b <= row_addr_lines_i[10] ? 4'h0 : open_b & ~(4'h1 << bk);
      end
      if (tk && op == 3'h0) begin
        cfg <= row_addr_lines_i;
      end
      cut <= {cut[1:0], endc};
      run <= dq_oe_o ? run + 9'h001 : 9'h000;
      rd_d1 <= rd_ok;
      rd_d2 <= rd_d1;
    end
  end
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_CL2_ON: assert property (rd_ok && !lat3 |=> ##1 dq_oe_o)
    else $error("no read data two edges after read at latency two");
  AST_CL3_ON: assert property (rd_ok && lat3 |=> ##2 dq_oe_o)
    else $error("no read data three edges after read at latency three");
  AST_CL3_LATE: assert property (rd_ok && lat3 && quiet
    |=> ##1 !dq_oe_o)
    else $error("data pins driven too early at latency three");
  AST_BL1: assert property ((rd_ok && !lat3 && cfg[2:0] == 3'h0
    && quiet) ##1 !endc |=> dq_oe_o ##1 !dq_oe_o)
    else $error("single-word burst not exactly one cycle");
  AST_BURST_MAX: assert property (dq_oe_o |-> run < blen)
    else $error("burst longer than programmed length");
  AST_PAGE_RUN: assert property (cfg[2:0] == 3'h7 && dq_oe_o && !endc
    && cut == 3'h0 |=> dq_oe_o)
    else $error("full-page burst ended on its own");
  AST_NO_ROW: assert property ((tk && op == 3'h5 && !open_b[bk]
    && quiet) ##1 !endc |=> !dq_oe_o ##1 !dq_oe_o)
    else $error("read to a bank without open row produced data");
  AST_WR_QUIET: assert property ((tk && op == 3'h4 && quiet)
    ##1 !endc |=> !dq_oe_o ##1 !dq_oe_o)
    else $error("write drove the data pins");
  AST_CFG_SET: assert property (tk && op == 3'h0 |=> cfg_loaded_o)
    else $error("configuration load not flagged");
  AST_CFG_KEEP: assert property (cfg_loaded_o |=> cfg_loaded_o)
    else $error("configuration flag dropped without reset");
  COV_CL3: cover property (rd_ok && lat3);
  COV_PAGE: cover property (rd_ok && cfg[2:0] == 3'h7);
  COV_IL: cover property (rd_ok && cfg[3]);
endmodule // sdb_core_monitor

bind sdb_core sdb_core_monitor #(.ROW_W(ROW_W)) u_sdb_core_monitor (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .cke_i(cke_i),
  .cs_n_i(cs_n_i),
  .ras_n_i(ras_n_i),
  .cas_n_i(cas_n_i),
  .we_n_i(we_n_i),
  .bank_sel_lo_i(bank_sel_lo_i),
  .bank_sel_hi_i(bank_sel_hi_i),
  .row_addr_lines_i(row_addr_lines_i),
  .dq_oe_o(dq_oe_o),
  .cfg_loaded_o(cfg_loaded_o)
);

// ==== verification/sdb_ctrl_model.sv ====
// Controller model driving commands, addresses and write data to the core.
// Assumes a free-running device clock; the bench calls its tasks.
`timescale 1ns/1ns
module sdb_ctrl_model #(
  parameter int INIT_NOPS = 2500
) (
  input wire logic sys_clk_i, // Device clock.
  output logic cke_o, // Clock enable.
  output logic [3:0] cmd_o, // Select and three strobes, active low.
  output logic [1:0] bank_o, // Bank select.
  output logic [11:0] addr_o, // Address lines.
  output logic [1:0] dqm_o, // Byte masks.
  output logic [15:0] dq_o // Write data.
);
  // --------------------------------------------------------------------
  // Command driver
  // --------------------------------------------------------------------
  initial begin
    cke_o = 1'b1;
    cmd_o = 4'h7;
    bank_o = 2'h0;
    addr_o = 12'h000;
    dqm_o = 2'h3;
    dq_o = 16'h0000;
  end
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    cmd_o <= c;
    bank_o <= b;
    addr_o <= a;
    dq_o <= d;
  endtask
  // Released data lines show the inverse of the last value.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      cmd_o <= 4'h7;
      dq_o <= ~dq_o;
    end
  endtask
  // Offers one command with the clock enable low, so the core must skip it.
  task automatic gated(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a);
    @(posedge sys_clk_i);
    cke_o <= 1'b0;
    cmd_o <= c;
    bank_o <= b;
    addr_o <= a;
    @(posedge sys_clk_i);
    cke_o <= 1'b1;
    cmd_o <= 4'h7;
  endtask
  // Sets the byte masks for the command issued in the same time step.
  task automatic set_mask(input logic [1:0] m);
    dqm_o <= m;
  endtask
  task automatic init(input logic [11:0] w);
    idle(INIT_NOPS);
    issue(4'h2, 2'h0, 12'h400, ~dq_o);
    idle(2);
    repeat (2) begin
      issue(4'h1, 2'h0, 12'h000, ~dq_o);
      idle(4);
    end
    issue(4'h0, 2'h0, w, ~dq_o);
    idle(2);
    dqm_o <= 2'h0;
  endtask
endmodule // sdb_ctrl_model

// ==== verification/tb_top.sv ====
// Self-checking bench of the DRAM core: start-up, burst orders, latencies.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] C_LD = 4'h0;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_RD = 4'h5;
  localparam logic [3:0] C_STOP = 4'h6;
  localparam logic [3:0] C_NOP = 4'h7;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cke;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [11:0] addr;
  logic [1:0] dqm;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic dq_oe;
  logic wr_ready;
  logic cfg_loaded;
  logic [15:0] mem [256];
  int err_total = 0;
  int total_checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  sdb_ctrl_model u_sdb_ctrl_model (
    .sys_clk_i(sys_clk_i),
    .cke_o(cke),
    .cmd_o(cmd),
    .bank_o(bank),
    .addr_o(addr),
    .dqm_o(dqm),
    .dq_o(dq_w)
  );
  sdb_core u_sdb_core (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cke_i(cke),
    .cs_n_i(cmd[3]),
    .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]),
    .we_n_i(cmd[0]),
    .bank_sel_lo_i(bank[0]),
    .bank_sel_hi_i(bank[1]),
    .row_addr_lines_i(addr),
    .dqm_i(dqm),
    .dq_i(dq_w),
    .dq_o(dq_r),
    .dq_oe_o(dq_oe),
    .wr_ready_o(wr_ready),
    .cfg_loaded_o(cfg_loaded)
  );
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ecol(input logic [7:0] s, input int k,
                                      input int len, input logic il);
    logic [7:0] m;
    logic [7:0] f;
    m = len[7:0] - 8'h01;
    f = il ? s ^ k[7:0] : s + k[7:0];
    return (s & ~m) | (f & m);
  endfunction
  task automatic wr8(input logic [7:0] s);
    for (int k = 0; k < 8; k++) begin
      mem[s + k[7:0]] = {8'h5A, s + k[7:0]};
      u_sdb_ctrl_model.issue(k == 0 ? C_WR : C_NOP, 2'h1, {4'h0, s},
                             {8'h5A, s + k[7:0]});
    end
    u_sdb_ctrl_model.idle(6);
  endtask
  task automatic setc(input logic [11:0] w);
    u_sdb_ctrl_model.issue(C_PRE, 2'h0, 12'h400, ~dq_w);
    u_sdb_ctrl_model.issue(C_LD, 2'h0, w, ~dq_w);
    u_sdb_ctrl_model.idle(2);
    u_sdb_ctrl_model.issue(C_ACT, 2'h1, 12'h005, ~dq_w);
    u_sdb_ctrl_model.idle(3);
  endtask
  task automatic rd(input logic [7:0] s, input int len, input logic il,
                    input int m);
    u_sdb_ctrl_model.issue(C_RD, 2'h1, {4'h0, s}, ~dq_w);
    u_sdb_ctrl_model.idle(m);
    for (int k = 0; k < (len == 256 ? 8 : len); k++) begin
      @(negedge sys_clk_i);
      chk({15'h0000, dq_oe}, 16'h0001);
      chk(dq_r, mem[ecol(s, k, len, il)]);
      u_sdb_ctrl_model.idle(1);
    end
    if (len == 256) begin
      u_sdb_ctrl_model.issue(C_STOP, 2'h1, 12'h000, ~dq_w);
      u_sdb_ctrl_model.idle(4);
    end
    @(negedge sys_clk_i);
    chk({15'h0000, dq_oe}, 16'h0000);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk({15'h0000, cfg_loaded}, 16'h0000);
    chk({15'h0000, wr_ready}, 16'h0001);
    u_sdb_ctrl_model.init(12'h023);
    chk({15'h0000, cfg_loaded}, 16'h0001);
    u_sdb_ctrl_model.issue(C_ACT, 2'h1, 12'h005, ~dq_w);
    u_sdb_ctrl_model.idle(3);
    wr8(8'h00);
    wr8(8'h08);
    wr8(8'hF8);
    for (int c = 2; c < 4; c++) begin
      for (int t = 0; t < 2; t++) begin
        for (int b = 0; b < 4; b++) begin
          setc({5'h00, c[2:0], t[0], b[2:0]});
          rd({5'h01, 3'(b * 3 + t + c)}, 1 << b, t[0], c);
        end
      end
    end
    setc(12'h027);
    rd(8'hFC, 256, 1'b0, 2);
    u_sdb_ctrl_model.issue(C_PRE, 2'h1, 12'h000, ~dq_w);
    u_sdb_ctrl_model.issue(C_RD, 2'h1, 12'h003, ~dq_w);
    u_sdb_ctrl_model.idle(4);
    @(negedge sys_clk_i);
    chk({15'h0000, dq_oe}, 16'h0000);
    setc(12'h222);
    u_sdb_ctrl_model.issue(C_WR, 2'h1, 12'h002, 16'hBEEF);
    for (int k = 0; k < 3; k++) begin
      u_sdb_ctrl_model.issue(C_NOP, 2'h1, 12'h002, 16'h1234);
    end
    u_sdb_ctrl_model.idle(6);
    mem[2] = 16'hBEEF;
    rd(8'h00, 4, 1'b0, 2);
    u_sdb_ctrl_model.idle(5);
    rd(8'h0D, 4, 1'b0, 2);
    setc(12'h020);
    u_sdb_ctrl_model.issue(C_ACT, 2'h3, 12'h009, ~dq_w);
    u_sdb_ctrl_model.idle(3);
    u_sdb_ctrl_model.issue(C_WR, 2'h3, 12'h002, 16'h1111);
    u_sdb_ctrl_model.issue(C_WR, 2'h3, 12'h002, 16'hA5C3);
    u_sdb_ctrl_model.set_mask(2'h2);
    u_sdb_ctrl_model.idle(1);
    u_sdb_ctrl_model.set_mask(2'h0);
    u_sdb_ctrl_model.idle(6);
    u_sdb_ctrl_model.gated(C_RD, 2'h3, 12'h002);
    u_sdb_ctrl_model.idle(1);
    @(negedge sys_clk_i);
    chk({15'h0000, dq_oe}, 16'h0000);
    u_sdb_ctrl_model.issue(C_RD, 2'h3, 12'h002, ~dq_w);
    u_sdb_ctrl_model.idle(2);
    @(negedge sys_clk_i);
    chk({15'h0000, dq_oe}, 16'h0001);
    chk(dq_r, 16'h11C3);
    rd(8'h02, 1, 1'b0, 2);
    stop_test();
  end
endmodule // tb_top
